// ==== drc_cfg.svh ====
`ifndef DRC_CFG_SVH
`define DRC_CFG_SVH

// decade wraps after this code
`define DRC_LAST_CODE 4'h9
// cleared state of the stage bits
`define DRC_INIT_CODE 4'h0
// highest trigger rate in kHz
`define DRC_MAX_RATE_KHZ 100
// clock rate in kHz
`define DRC_CLK_KHZ 100000
// trigger period in clock cycles at the highest rate
`define DRC_MIN_PERIOD_CYC (`DRC_CLK_KHZ / `DRC_MAX_RATE_KHZ)

`endif

// ==== drc_pkg.sv ====
package drc_pkg;

  typedef struct packed {
    logic [3:0] stage_true_out;
    logic [3:0] stage_complement_out;
  } drc_stage_out_t;

  typedef enum logic [1:0] {
    DRC_COUNTING,
    DRC_CLEARED
  } drc_mode_t;

endpackage

// ==== drc_decade.sv ====
`timescale 1ns/1ps
`include "drc_cfg.svh"

module drc_decade
  import drc_pkg::*;
(
  core_clk,
  arst_n,
  count_step_input,
  clear_level_input,
  stage_out,
  top_stage_complement_out,
  count_mode
);
  input wire logic core_clk;
  input wire logic arst_n;
  input wire logic count_step_input;
  input wire logic clear_level_input;
  output drc_stage_out_t stage_out;
  output logic top_stage_complement_out;
  output drc_mode_t count_mode;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] step_sync_ff;
  logic step_prev_ff;
  logic [1:0] clear_sync_ff;
  logic step_rise;
  logic clear_now;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      step_sync_ff <= 2'h0;
      clear_sync_ff <= 2'h0;
      step_prev_ff <= 1'b0;
    end else begin
      step_sync_ff <= {step_sync_ff[0], count_step_input};
      clear_sync_ff <= {clear_sync_ff[0], clear_level_input};
      step_prev_ff <= step_sync_ff[1];
    end
  end

  // falling steps never count
  assign step_rise = step_sync_ff[1] & ~step_prev_ff;
  assign clear_now = clear_sync_ff[1];

  // ---------------------------------------------------------------
  // decade state
  // ---------------------------------------------------------------
  logic [3:0] count_ff;
  logic [3:0] nxt_count;
  drc_mode_t mode_ff;

  // 8-4-2-1 code; the gate skips codes A..F
  function automatic logic [3:0] drc_advance(input logic [3:0] code);
    if (code >= `DRC_LAST_CODE) begin
      drc_advance = `DRC_INIT_CODE;
    end else begin
      drc_advance = code + 4'h1;
    end
  endfunction

  always_comb begin
    nxt_count = count_ff;
    if (clear_now) begin
      nxt_count = `DRC_INIT_CODE;
    end else if (step_rise) begin
      nxt_count = drc_advance(count_ff);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_ff <= `DRC_INIT_CODE;
    end else begin
      count_ff <= nxt_count;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_ff <= DRC_COUNTING;
    end else begin
      mode_ff <= clear_now ? DRC_CLEARED : DRC_COUNTING;
    end
  end

  // ---------------------------------------------------------------
  // outputs, registered
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_out.stage_true_out <= 4'h0;
      stage_out.stage_complement_out <= 4'hF;
      top_stage_complement_out <= 1'b1;
    end else begin
      stage_out.stage_true_out <= nxt_count;
      stage_out.stage_complement_out <= ~nxt_count;
      // rises once per decade wrap, carry for the next decade
      top_stage_complement_out <= ~nxt_count[3];
    end
  end

  assign count_mode = mode_ff;

endmodule

// ==== drc_decade_ripple_counter.sv ====
`timescale 1ns/1ps
`include "drc_cfg.svh"

module drc_decade_ripple_counter
  import drc_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic count_step_input_first,
  input wire logic clear_level_input_first,
  input wire logic count_step_input_second,
  input wire logic clear_level_input_second,
  output drc_stage_out_t stage_out_first,
  output drc_stage_out_t stage_out_second,
  output logic top_stage_complement_out,
  output logic top_stage_complement_out_second,
  output drc_mode_t mode_first,
  output drc_mode_t mode_second
);

  // ---------------------------------------------------------------
  // two identical decades, no shared state
  // ---------------------------------------------------------------
  // 100 kHz trigger period is far longer than the sync latency, so no step is lost
  drc_decade u_first (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .count_step_input(count_step_input_first),
    .clear_level_input(clear_level_input_first),
    .stage_out(stage_out_first),
    .top_stage_complement_out(top_stage_complement_out),
    .count_mode(mode_first)
  );

  drc_decade u_second (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .count_step_input(count_step_input_second),
    .clear_level_input(clear_level_input_second),
    .stage_out(stage_out_second),
    .top_stage_complement_out(top_stage_complement_out_second),
    .count_mode(mode_second)
  );

endmodule

// ==== drc_pulse_src.sv ====
`timescale 1ns/1ps
module drc_pulse_src
(
  input wire logic core_clk,
  output logic step
);
  initial step = 1'b0;
  // w >= 3 keeps high and low wide enough for the input syncs
  task automatic fire(input int n, input int w);
    repeat (n) begin
      @(posedge core_clk) step <= 1'b1;
      repeat (w) @(posedge core_clk);
      step <= 1'b0;
      repeat (w) @(posedge core_clk);
    end
  endtask
endmodule

// ==== drc_decade_ripple_counter_checker.sv ====
`timescale 1ns/1ps
module drc_checker
  import drc_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic count_step_input_first,
  input wire logic clear_level_input_first,
  input drc_stage_out_t stage_out_first,
  input drc_stage_out_t stage_out_second,
  input wire logic top_stage_complement_out
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  logic [3:0] t;
  logic cl;
  assign t = stage_out_first.stage_true_out;
  assign cl = clear_level_input_first;
  sequence s_rise;
    !cl[*4] ##0 $rose(count_step_input_first);
  endsequence
  sequence s_quiet;
    (!$rose(count_step_input_first) && !cl)[*5];
  endsequence
  AST_COMPL: assert property (stage_out_first.stage_complement_out == ~t)
    else $error("complement wrong");
  AST_RANGE: assert property (stage_out_second.stage_true_out <= 4'h9)
    else $error("code out of range");
  AST_CLEAR: assert property (cl[*4] |-> t == 4'h0)
    else $error("clear not held");
  AST_ADV: assert property (s_rise |-> ##[2:4] $changed(t))
    else $error("step not counted");
  AST_HOLD: assert property (s_quiet |-> $stable(t))
    else $error("count moved");
  AST_SEQ: assert property ($changed(t) |-> t == 4'h0 || t == $past(t) + 4'h1)
    else $error("bad order");
  AST_CARRY: assert property (!cl[*5] ##0 $rose(top_stage_complement_out)
    |-> $past(t) == 4'h9 && t == 4'h0) else $error("bad carry");
  AST_TOP: assert property (top_stage_complement_out == ~t[3])
    else $error("top output wrong");
endmodule
bind drc_decade_ripple_counter drc_checker u_chk (.core_clk, .arst_n,
  .count_step_input_first, .clear_level_input_first, .stage_out_first,
  .stage_out_second, .top_stage_complement_out);

// ==== drc_decade_ripple_counter_test.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module drc_decade_ripple_counter_test;
  import drc_pkg::*;
  logic core_clk, arst_n, clr1, clr2, top1, top2;
  wire logic st1, st2;
  drc_stage_out_t so1, so2;
  drc_mode_t md1, md2;
  logic [3:0] e1, e2;
  int n_errors, checks, cyc, n, m, w;
  drc_decade_ripple_counter DUT (.core_clk, .arst_n,
    .count_step_input_first(st1), .clear_level_input_first(clr1),
    .count_step_input_second(st2), .clear_level_input_second(clr2),
    .stage_out_first(so1), .stage_out_second(so2),
    .top_stage_complement_out(top1), .top_stage_complement_out_second(top2),
    .mode_first(md1), .mode_second(md2));
  drc_pulse_src src1 (.core_clk, .step(st1));
  drc_pulse_src src2 (.core_clk, .step(st2));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [3:0] adv(logic [3:0] c, int k);
    repeat (k) c = (c == 4'h9) ? 4'h0 : c + 4'h1;
    return c;
  endfunction
  task automatic check_all;
    repeat (6) @(posedge core_clk);
    #1;
    `CHK(so1.stage_true_out, e1)
    `CHK(so1.stage_complement_out, ~e1)
    `CHK(top1, ~e1[3])
    `CHK(so2.stage_true_out, e2)
    `CHK(so2.stage_complement_out, ~e2)
    `CHK(top2, ~e2[3])
  endtask
  task final_report;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // -------
  // timeout
  // -------
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    {arst_n, clr1, clr2, e1, e2} = '0;
    void'($urandom(32'h15ED));
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    check_all();
    for (int i = 0; i < 40; i++) begin
      n = (i == 0) ? 10 : $urandom_range(1, 12);
      m = $urandom_range(0, 5);
      w = $urandom_range(3, 9);
      fork
        src1.fire(n, w);
        src2.fire(m, 3 + w % 2);
      join
      e1 = adv(e1, n);
      e2 = adv(e2, m);
      check_all();
    end
    for (int k = 0; k < 2; k++) begin
      @(posedge core_clk);
      clr1 <= (k == 0);
      clr2 <= (k == 1);
      fork
        src1.fire(3, 3);
        src2.fire(3, 3);
      join
      e1 = (k == 0) ? 4'h0 : adv(e1, 3);
      e2 = (k == 1) ? 4'h0 : adv(e2, 3);
      check_all();
      `CHK(md1, (k == 0) ? DRC_CLEARED : DRC_COUNTING)
      `CHK(md2, (k == 1) ? DRC_CLEARED : DRC_COUNTING)
    end
    clr2 <= 1'b0;
    check_all();
    final_report();
  end
endmodule
